// ### waveform_replay_controller_bench.sv
`timescale 1ns/100ps
// =====================================================================
// Self-checking bench: register tasks, replay runs, captured samples.
module waveform_replay_controller_bench;
  logic                      sys_clk = 1'b0;
  logic                      rst     = 1'b1;
  logic [wrc_pkg::RAW-1:0]   reg_addr;
  logic [wrc_pkg::DW-1:0]    reg_wdata, reg_rdata, dac_data, v;
  logic                      reg_wr, reg_rd, dac_valid, irq;
  logic                      cmp_hi_pin, cmp_lo_pin, trig2_pin, gate_pin;
  logic [7:0]                ana_lvl;
  logic                      t2_lvl, gt_lvl, hub_synced;
  logic [wrc_pkg::DW-1:0]    cap[$];
  int                        mismatches = 0;
  int                        n_tests    = 0;

  // Clock at 40 MHz.
  always #12.5 sys_clk = ~sys_clk;

  wrc_top uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmp_hi_pin(cmp_hi_pin),
    .cmp_lo_pin(cmp_lo_pin), .trig2_pin(trig2_pin), .gate_pin(gate_pin),
    .hub_synced(hub_synced), .dac_data(dac_data), .dac_valid(dac_valid), .irq(irq));

  wrc_far far (.sys_clk(sys_clk), .ana_lvl(ana_lvl), .t2_lvl(t2_lvl), .gt_lvl(gt_lvl),
    .cmp_hi_pin(cmp_hi_pin), .cmp_lo_pin(cmp_lo_pin), .trig2_pin(trig2_pin),
    .gate_pin(gate_pin));

  // Every sample handed to the converter is kept for later comparison.
  always @(posedge sys_clk) begin
    if (dac_valid === 1'b1) cap.push_back(dac_data);
  end

  // Memory word i holds a pattern that also reveals its index modulo four.
  function automatic logic [15:0] smp(input int i);
    return 16'h5a00 | 16'(i % 4);
  endfunction

  task automatic conclude();
    $display("Counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic state_is(input logic [1:0] s, input string what);
    rd(wrc_pkg::A_STAT, v);
    chk({14'h0000, v[1:0]}, {14'h0000, s}, what);
  endtask

  // The captured run must be n samples walking through memory in order.
  task automatic run_chk(input int n, input string what);
    chk(16'(cap.size()), 16'(n), what);
    foreach (cap[i]) chk(cap[i], smp(i), what);
    cap.delete();
  endtask

  task automatic arm(input logic [15:0] ctrl);
    wr(wrc_pkg::A_CTRL, ctrl);
    cap.delete();
    wr(wrc_pkg::A_CMD, 16'h0001);
  endtask

  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end

  // =====================================================================
  // Main sequence.
  initial begin
    reg_addr = 4'h0; reg_wdata = 16'h0000; reg_wr = 1'b0; reg_rd = 1'b0;
    ana_lvl = 8'h00; t2_lvl = 1'b0; gt_lvl = 1'b0;
    hub_synced = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    state_is(2'h0, "idle after reset");
    wr(4'hc, 16'hffff);
    rd(4'hc, v);
    chk(v, 16'h0000, "unmapped index");
    wr(wrc_pkg::A_MADDR, 16'h0000);
    for (int i = 0; i < 4; i++) wr(wrc_pkg::A_MDATA, smp(i));
    wr(wrc_pkg::A_MEND, 16'h0003);
    wr(wrc_pkg::A_IRQ, 16'h000f);
    wr(wrc_pkg::A_MASK, 16'h0000);
    // Single shot by software trigger; a second trigger mid-run is ignored.
    arm(16'h0000);
    wr(wrc_pkg::A_CMD, 16'h0004);
    wr(wrc_pkg::A_CMD, 16'h0004);
    cyc(30);
    run_chk(4, "single shot");
    state_is(2'h0, "idle after single");
    chk({15'h0000, irq}, 16'h0000, "masked irq");
    wr(wrc_pkg::A_MASK, 16'h0001);
    #1 chk({15'h0000, irq}, 16'h0001, "done irq");
    wr(wrc_pkg::A_IRQ, 16'h0001);
    #1 chk({15'h0000, irq}, 16'h0000, "irq cleared");
    $display("Test single and interrupt finished");
    // Repeated output, two loops back to back.
    wr(wrc_pkg::A_LOOPS, 16'h0002);
    arm(16'h0001);
    wr(wrc_pkg::A_CMD, 16'h0004);
    cyc(40);
    run_chk(8, "repeat twice");
    // Endless repeat ended by a stop command.
    wr(wrc_pkg::A_LOOPS, 16'h0000);
    arm(16'h0001);
    wr(wrc_pkg::A_CMD, 16'h0004);
    cyc(25);
    wr(wrc_pkg::A_CMD, 16'h0002);
    cyc(2);
    cap.delete();
    cyc(20);
    chk(16'(cap.size()), 16'h0000, "silent after stop");
    state_is(2'h0, "idle after stop");
    $display("Test repeat and stop finished");
    // Restart on rising edges of the second input, re-arming in between.
    arm(16'h000a);
    for (int k = 0; k < 2; k++) begin
      t2_lvl <= 1'b1;
      cyc(20);
      t2_lvl <= 1'b0;
      cyc(10);
    end
    run_chk(8, "restart twice");
    state_is(2'h1, "re-armed");
    wr(wrc_pkg::A_CMD, 16'h0002);
    // Single shot from the first input; the second crossing is ignored.
    arm(16'h0008);
    ana_lvl <= 8'hff;
    cyc(2);
    ana_lvl <= 8'h00;
    cyc(2);
    ana_lvl <= 8'hff;
    cyc(30);
    run_chk(4, "external edge");
    ana_lvl <= 8'h00;
    $display("Test external triggers finished");
    // Gated replay holds still until the gate reaches its active level.
    arm(16'h0025);
    cyc(20);
    chk(16'(cap.size()), 16'h0000, "gate closed");
    gt_lvl <= 1'b1;
    cyc(12);
    chk(16'(cap.size() > 0), 16'h0001, "gate open");
    chk(cap[0], smp(0), "gate first sample");
    gt_lvl <= 1'b0;
    wr(wrc_pkg::A_CMD, 16'h0002);
    $display("Test gated replay finished");
    // Multi replay: each trigger plays the next two-word segment, wrapping.
    wr(wrc_pkg::A_SLEN, 16'h0002);
    arm(16'h0004);
    for (int k = 0; k < 3; k++) begin
      wr(wrc_pkg::A_CMD, 16'h0004);
      cyc(6);
    end
    run_chk(6, "multi segments");
    state_is(2'h1, "multi re-armed");
    wr(wrc_pkg::A_CMD, 16'h0002);
    // Streaming: ten words queued ahead are drained, then the ring runs dry.
    wr(wrc_pkg::A_CTRL, 16'h0003);
    wr(wrc_pkg::A_MADDR, 16'h0000);
    for (int i = 0; i < 10; i++) wr(wrc_pkg::A_MDATA, smp(i));
    wr(wrc_pkg::A_IRQ, 16'h000f);
    arm(16'h0003);
    cyc(30);
    run_chk(10, "stream");
    rd(wrc_pkg::A_IRQ, v);
    chk(v, 16'h0006, "refill and underrun");
    wr(wrc_pkg::A_CMD, 16'h0002);
    // Sequence: entry 0 plays words 2-3 twice, entry 1 waits, plays 0-1.
    wr(wrc_pkg::A_SADDR, 16'h0000);
    wr(wrc_pkg::A_SDATA, 16'h2232);
    wr(wrc_pkg::A_SDATA, 16'h1110);
    arm(16'h0006);
    cyc(20);
    wr(wrc_pkg::A_CMD, 16'h0004);
    cyc(20);
    chk(16'(cap.size()), 16'h000a, "sequence length");
    foreach (cap[i]) chk(cap[i], smp((i inside {[4:5]}) ? i : 2 + i % 2), "order");
    cap.delete();
    hub_synced <= 1'b1;
    cyc(4);
    chk(cap[0], smp(0), "synced skips wait");
    wr(wrc_pkg::A_CMD, 16'h0008);
    wr(wrc_pkg::A_CMD, 16'h0002);
    hub_synced <= 1'b0;
    $display("Test multi, stream and sequence finished");
    conclude();
  end
endmodule // waveform_replay_controller_bench

// ### wrc_far.sv
`timescale 1ns/100ps
// =====================================================================
// Far-side model: a signal source that feeds the two comparators of the
// first trigger input, the logic level of the second input and the gate.
module wrc_far #(
  parameter logic [7:0] HI_LVL = 8'hc0,
  parameter logic [7:0] LO_LVL = 8'h40
) (
  // Clock.
  input  wire logic       sys_clk,
  // Commanded source levels.
  input  wire logic [7:0] ana_lvl,
  input  wire logic       t2_lvl,
  input  wire logic       gt_lvl,
  // Pins toward the block.
  output logic            cmp_hi_pin,
  output logic            cmp_lo_pin,
  output logic            trig2_pin,
  output logic            gate_pin
);
  // Pins idle low from time zero, so the block never sees an unknown level.
  initial begin
    cmp_hi_pin = 1'b0;
    cmp_lo_pin = 1'b0;
    trig2_pin  = 1'b0;
    gate_pin   = 1'b0;
  end

  // Both comparators slice one analog level, as a real front end would.
  // Pins move on the rising edge itself, in step with the block's sampling.
  always @(posedge sys_clk) begin
    cmp_hi_pin <= ana_lvl > HI_LVL;
    cmp_lo_pin <= ana_lvl > LO_LVL;
    trig2_pin  <= t2_lvl;
    gate_pin   <= gt_lvl;
  end
endmodule // wrc_far

// ### wrc_pkg.sv
// =====================================================================
// Shared constants of the waveform replay controller.
package wrc_pkg;

  // Storage sizes.
  localparam int DW    = 16;
  localparam int AW    = 4;
  localparam int DEPTH = 16;
  localparam int NSEQ  = 4;
  localparam int SQW   = 2;
  localparam int RAW   = 4;
  localparam int NIRQ  = 4;

  // Register indices on the plain register port.
  localparam logic [RAW-1:0] A_CTRL  = 4'h0;
  localparam logic [RAW-1:0] A_CMD   = 4'h1;
  localparam logic [RAW-1:0] A_LOOPS = 4'h2;
  localparam logic [RAW-1:0] A_MEND  = 4'h3;
  localparam logic [RAW-1:0] A_SLEN  = 4'h4;
  localparam logic [RAW-1:0] A_MADDR = 4'h5;
  localparam logic [RAW-1:0] A_MDATA = 4'h6;
  localparam logic [RAW-1:0] A_SADDR = 4'h7;
  localparam logic [RAW-1:0] A_SDATA = 4'h8;
  localparam logic [RAW-1:0] A_STAT  = 4'h9;
  localparam logic [RAW-1:0] A_IRQ   = 4'ha;
  localparam logic [RAW-1:0] A_MASK  = 4'hb;

  // Control register fields.
  localparam int C_MODE = 0;
  localparam int C_SRC  = 3;
  localparam int C_GPOL = 5;
  localparam int C_T1M  = 6;
  localparam int C_T2M  = 8;

  // Command register bits.
  localparam int K_START = 0;
  localparam int K_STOP  = 1;
  localparam int K_TRIG  = 2;
  localparam int K_JUMP  = 3;
  localparam int K_JTGT  = 4;

  // Sequence entry fields.
  localparam int Q_START = 0;
  localparam int Q_END   = 4;
  localparam int Q_LOOPS = 8;
  localparam int Q_WAIT  = 12;
  localparam int Q_NEXT  = 13;

  // Interrupt status bits.
  localparam int I_DONE   = 0;
  localparam int I_REFILL = 1;
  localparam int I_UNDER  = 2;
  localparam int I_TRIG   = 3;

  // Counting steps, the full level and the refill threshold of the streaming buffer.
  localparam logic [AW-1:0] A_ONE    = 4'h1;
  localparam logic [DW-1:0] D_ONE    = 16'h0001;
  localparam logic [AW:0]   F_ONE    = 5'h01;
  localparam logic [AW:0]   F_FULL   = 5'h10;
  localparam logic [AW:0]   F_REFILL = 5'h08;

  // Trigger sources.
  localparam logic [1:0] S_SW  = 2'h0;
  localparam logic [1:0] S_EX1 = 2'h1;
  localparam logic [1:0] S_EX2 = 2'h2;

  typedef enum logic [2:0] {
    M_SINGLE  = 3'b000,
    M_REPEAT  = 3'b001,
    M_RESTART = 3'b010,
    M_FIFO    = 3'b011,
    M_MULTI   = 3'b100,
    M_GATE    = 3'b101,
    M_SEQ     = 3'b110
  } wrc_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_RUN   = 2'b10
  } wrc_state_t;

endpackage

// ### wrc_top.sv
`timescale 1ns/100ps
// =====================================================================
// What this block does
// - Single shot plays memory once, then stops.
// - Start trigger from external input or software.
// - Later triggers ignored until run ends.
// - Repeat plays loop count times or forever.
// - Restart plays once per trigger, then re-arms.
// - Streaming uses whole memory as ring buffer.
// - Streaming raises refill interrupts for host.
// - Multi replay plays next equal segment per trigger.
// - Gated replay advances only while gate active.
// - Sequence plays variable segments per table order.
// - Table entry holds loop count and trigger wait.
// - Software jump on standalone unit; host rewrites idle segments live.
// - Trigger advancing needed only on standalone unit.
// - Two external trigger inputs, analog or digital.
// - Input one: edge, window, hysteresis, re-arm.
// - Input two: edge and level only.
module wrc_top (
  // Clock and reset.
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  // Register port.
  input  wire logic [wrc_pkg::RAW-1:0]  reg_addr,
  input  wire logic [wrc_pkg::DW-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [wrc_pkg::DW-1:0]   reg_rdata,
  // External trigger and gate pins.
  input  wire logic                     cmp_hi_pin,
  input  wire logic                     cmp_lo_pin,
  input  wire logic                     trig2_pin,
  input  wire logic                     gate_pin,
  input  wire logic                     hub_synced,
  // Converter output and interrupt.
  output logic      [wrc_pkg::DW-1:0]   dac_data,
  output logic                          dac_valid,
  output logic                          irq
);

  typedef struct packed {
    wrc_pkg::wrc_state_t                          st;
    logic [wrc_pkg::DW-1:0]                       ctrl;
    logic [wrc_pkg::DW-1:0]                       loops;
    logic [wrc_pkg::DW-1:0]                       lcnt;
    logic [wrc_pkg::AW-1:0]                       mend;
    logic [wrc_pkg::AW-1:0]                       slen;
    logic [wrc_pkg::AW-1:0]                       maddr;
    logic [wrc_pkg::AW-1:0]                       rd;
    logic [wrc_pkg::AW-1:0]                       segb;
    logic [wrc_pkg::AW:0]                         fill;
    logic [wrc_pkg::SQW-1:0]                      seqa;
    logic [wrc_pkg::SQW-1:0]                      ent;
    logic                                         jpend;
    logic [wrc_pkg::SQW-1:0]                      jtgt;
    logic [wrc_pkg::NIRQ-1:0]                     irqs;
    logic [wrc_pkg::NIRQ-1:0]                     mask;
    logic [wrc_pkg::DW-1:0]                       dac;
    logic                                         val;
    logic [wrc_pkg::DW-1:0]                       rdat;
    logic [wrc_pkg::NSEQ-1:0][wrc_pkg::DW-1:0]    seq;
    logic [wrc_pkg::DEPTH-1:0][wrc_pkg::DW-1:0]   mem;
  } wrc_st_t;

  wrc_st_t q;
  wrc_st_t d;

  logic                         t1_hit, t2_hit, gate_lvl;
  logic                         cmd_wr, trg, last, gate_ok, fifo_wr, fifo_rd;
  logic [wrc_pkg::NIRQ-1:0]     ev;
  logic [wrc_pkg::AW-1:0]       seg_end, nxt_start;
  logic [wrc_pkg::AW:0]         nb;
  logic [wrc_pkg::DW-1:0]       cur_e, nxt_e;
  logic [wrc_pkg::SQW-1:0]      nxt_i;
  wrc_pkg::wrc_mode_t           mode;

  // Field decoders for a sequence table entry.
  function automatic logic [wrc_pkg::AW-1:0] e_start(input logic [wrc_pkg::DW-1:0] e);
    e_start = e[wrc_pkg::Q_START +: wrc_pkg::AW];
  endfunction

  function automatic logic e_wait(input logic [wrc_pkg::DW-1:0] e, input logic hub);
    e_wait = e[wrc_pkg::Q_WAIT] & ~hub;
  endfunction

  wrc_trig u_trig (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .cmp_hi_pin (cmp_hi_pin),
    .cmp_lo_pin (cmp_lo_pin),
    .trig2_pin  (trig2_pin),
    .gate_pin   (gate_pin),
    .t1_mode    (q.ctrl[wrc_pkg::C_T1M +: 2]),
    .t2_mode    (q.ctrl[wrc_pkg::C_T2M +: 2]),
    .t1_hit     (t1_hit),
    .t2_hit     (t2_hit),
    .gate_lvl   (gate_lvl)
  );

  // =====================================================================
  // Decodes shared by the sequencer and the assertions.
  always_comb begin
    mode   = wrc_pkg::wrc_mode_t'(q.ctrl[wrc_pkg::C_MODE +: 3]);
    cmd_wr = reg_wr && (reg_addr == wrc_pkg::A_CMD);
    // Restart mode knows only the logic-level input besides software.
    trg = (cmd_wr && reg_wdata[wrc_pkg::K_TRIG])
        | ((q.ctrl[wrc_pkg::C_SRC +: 2] == wrc_pkg::S_EX1)
           && ((mode == wrc_pkg::M_RESTART) ? t2_hit : t1_hit))
        | ((q.ctrl[wrc_pkg::C_SRC +: 2] == wrc_pkg::S_EX2) && t2_hit);
    gate_ok   = (gate_lvl == q.ctrl[wrc_pkg::C_GPOL]);
    cur_e     = q.seq[q.ent];
    nxt_i     = q.jpend ? q.jtgt : cur_e[wrc_pkg::Q_NEXT +: wrc_pkg::SQW];
    nxt_e     = q.seq[nxt_i];
    nxt_start = e_start(nxt_e);
    nb        = {1'b0, q.segb} + {1'b0, q.slen};
    case (mode)
      wrc_pkg::M_MULTI: seg_end = q.segb + q.slen - wrc_pkg::A_ONE;
      wrc_pkg::M_SEQ:   seg_end = cur_e[wrc_pkg::Q_END +: wrc_pkg::AW];
      default:          seg_end = q.mend;
    endcase
    last    = (q.rd == seg_end);
    fifo_wr = reg_wr && (reg_addr == wrc_pkg::A_MDATA) && (mode == wrc_pkg::M_FIFO)
              && (q.fill != wrc_pkg::F_FULL);
    fifo_rd = (mode == wrc_pkg::M_FIFO) && (q.st == wrc_pkg::ST_RUN)
              && (q.fill != '0);
  end

  // =====================================================================
  // Next state: register writes, replay sequencing, interrupts.
  always_comb begin
    d     = q;
    ev    = '0;
    d.val = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        wrc_pkg::A_CTRL:  d.ctrl  = reg_wdata;
        wrc_pkg::A_LOOPS: d.loops = reg_wdata;
        wrc_pkg::A_MEND:  d.mend  = reg_wdata[wrc_pkg::AW-1:0];
        wrc_pkg::A_SLEN:  d.slen  = reg_wdata[wrc_pkg::AW-1:0];
        wrc_pkg::A_MADDR: begin
          d.maddr = reg_wdata[wrc_pkg::AW-1:0];
          d.fill  = '0;
        end
        // Writes land anywhere, so idle segments may change mid-sequence.
        wrc_pkg::A_MDATA: begin
          if (mode != wrc_pkg::M_FIFO || fifo_wr) begin
            d.mem[q.maddr] = reg_wdata;
            d.maddr        = q.maddr + wrc_pkg::A_ONE;
          end
        end
        wrc_pkg::A_SADDR: d.seqa = reg_wdata[wrc_pkg::SQW-1:0];
        wrc_pkg::A_SDATA: begin
          d.seq[q.seqa] = reg_wdata;
          d.seqa        = q.seqa + 1'b1;
        end
        wrc_pkg::A_MASK:  d.mask  = reg_wdata[wrc_pkg::NIRQ-1:0];
        default: ;
      endcase
    end
    // Fill level follows host writes and replay reads of the ring. A pointer
    // load empties the ring, so that cycle must not be counted over again.
    if (!(reg_wr && reg_addr == wrc_pkg::A_MADDR)) begin
      d.fill = q.fill + (fifo_wr ? wrc_pkg::F_ONE : '0) - (fifo_rd ? wrc_pkg::F_ONE : '0);
    end
    if (cmd_wr && reg_wdata[wrc_pkg::K_JUMP] && !hub_synced) begin
      d.jpend = 1'b1;
      d.jtgt  = reg_wdata[wrc_pkg::K_JTGT +: wrc_pkg::SQW];
    end
    if (cmd_wr && reg_wdata[wrc_pkg::K_START]) begin
      d.st    = wrc_pkg::ST_ARMED;
      d.lcnt  = '0;
      d.ent   = '0;
      d.segb  = '0;
      d.jpend = 1'b0;
      d.rd    = (mode == wrc_pkg::M_SEQ) ? e_start(q.seq[0]) : '0;
    end
    case (q.st)
      wrc_pkg::ST_ARMED: begin
        // Gate and stream runs need no trigger; a table entry may not want one.
        if (mode == wrc_pkg::M_FIFO || mode == wrc_pkg::M_GATE
            || (mode == wrc_pkg::M_SEQ && !e_wait(cur_e, hub_synced)) || trg) begin
          d.st = wrc_pkg::ST_RUN;
          ev[wrc_pkg::I_TRIG] = trg;
        end
      end
      wrc_pkg::ST_RUN: begin
        // Triggers are not looked at while running.
        if (mode == wrc_pkg::M_FIFO) begin
          if (fifo_rd) begin
            d.val = 1'b1;
            d.dac = q.mem[q.rd];
            d.rd  = q.rd + wrc_pkg::A_ONE;
            ev[wrc_pkg::I_REFILL] = (q.fill == wrc_pkg::F_REFILL + wrc_pkg::F_ONE);
          end else begin
            ev[wrc_pkg::I_UNDER] = 1'b1;
          end
        end else if (mode == wrc_pkg::M_GATE) begin
          // The read pointer holds while the gate is inactive.
          if (gate_ok) begin
            d.val = 1'b1;
            d.dac = q.mem[q.rd];
            d.rd  = last ? '0 : q.rd + wrc_pkg::A_ONE;
          end
        end else begin
          d.val = 1'b1;
          d.dac = q.mem[q.rd];
          d.rd  = q.rd + wrc_pkg::A_ONE;
          if (last) begin
            case (mode)
              wrc_pkg::M_SINGLE: begin
                d.st = wrc_pkg::ST_IDLE;
                ev[wrc_pkg::I_DONE] = 1'b1;
              end
              wrc_pkg::M_REPEAT: begin
                d.rd   = '0;
                d.lcnt = q.lcnt + wrc_pkg::D_ONE;
                // A loop count of zero means run until stopped.
                if (q.loops != '0 && q.lcnt + wrc_pkg::D_ONE == q.loops) begin
                  d.st = wrc_pkg::ST_IDLE;
                  ev[wrc_pkg::I_DONE] = 1'b1;
                end
              end
              wrc_pkg::M_RESTART: begin
                d.rd = '0;
                d.st = wrc_pkg::ST_ARMED;
              end
              wrc_pkg::M_MULTI: begin
                // Next equal segment, wrapping to the first past memory end.
                d.segb = (nb > {1'b0, q.mend}) ? '0 : nb[wrc_pkg::AW-1:0];
                d.rd   = d.segb;
                d.st   = wrc_pkg::ST_ARMED;
              end
              wrc_pkg::M_SEQ: begin
                // Loop the entry, then follow its link or a pending jump.
                if (q.lcnt[3:0] + 4'h1 < cur_e[wrc_pkg::Q_LOOPS +: 4]) begin
                  d.lcnt = q.lcnt + wrc_pkg::D_ONE;
                  d.rd   = e_start(cur_e);
                end else begin
                  d.lcnt  = '0;
                  d.ent   = nxt_i;
                  d.jpend = 1'b0;
                  d.rd    = nxt_start;
                  if (e_wait(nxt_e, hub_synced)) begin
                    d.st = wrc_pkg::ST_ARMED;
                  end
                end
              end
              default: d.st = wrc_pkg::ST_IDLE;
            endcase
          end
        end
      end
      default: ;
    endcase
    // Stop overrides everything and drops output at once.
    if (cmd_wr && reg_wdata[wrc_pkg::K_STOP]) begin
      d.st  = wrc_pkg::ST_IDLE;
      d.val = 1'b0;
    end
    // New events win over a same-cycle write-one clear.
    d.irqs = ((reg_wr && reg_addr == wrc_pkg::A_IRQ)
              ? (q.irqs & ~reg_wdata[wrc_pkg::NIRQ-1:0]) : q.irqs) | ev;
    // Read data appear in the cycle after the strobe only.
    d.rdat = '0;
    if (reg_rd) begin
      case (reg_addr)
        wrc_pkg::A_CTRL:  d.rdat = q.ctrl;
        wrc_pkg::A_LOOPS: d.rdat = q.loops;
        wrc_pkg::A_MEND:  d.rdat = {12'h000, q.mend};
        wrc_pkg::A_SLEN:  d.rdat = {12'h000, q.slen};
        wrc_pkg::A_MADDR: d.rdat = {12'h000, q.maddr};
        wrc_pkg::A_MDATA: d.rdat = q.mem[q.maddr];
        wrc_pkg::A_SADDR: d.rdat = {14'h0000, q.seqa};
        wrc_pkg::A_SDATA: d.rdat = q.seq[q.seqa];
        wrc_pkg::A_STAT:  d.rdat = {3'h0, q.fill, q.rd, q.ent, q.st};
        wrc_pkg::A_IRQ:   d.rdat = {12'h000, q.irqs};
        wrc_pkg::A_MASK:  d.rdat = {12'h000, q.mask};
        default:          d.rdat = '0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdat;
  assign dac_data  = q.dac;
  assign dac_valid = q.val;
  assign irq       = |(q.irqs & q.mask);

  // =====================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_stop_idle: assert property (cmd_wr && reg_wdata[wrc_pkg::K_STOP]
    |=> q.st == wrc_pkg::ST_IDLE && !dac_valid) else $error("stop did not idle");
  a_single_end: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_SINGLE
    && last && !cmd_wr |=> q.st == wrc_pkg::ST_IDLE && q.irqs[wrc_pkg::I_DONE])
    else $error("single shot did not end");
  a_trig_start: assert property (q.st == wrc_pkg::ST_ARMED && mode == wrc_pkg::M_SINGLE
    && trg && !cmd_wr |=> q.st == wrc_pkg::ST_RUN ##1 dac_valid)
    else $error("trigger did not start");
  a_run_noretrig: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_REPEAT
    && !last && !cmd_wr |=> q.st == wrc_pkg::ST_RUN && q.rd == $past(q.rd) + wrc_pkg::A_ONE)
    else $error("run disturbed");
  a_rep_forever: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_REPEAT
    && last && q.loops == '0 && !cmd_wr |=> q.st == wrc_pkg::ST_RUN && q.rd == '0)
    else $error("endless repeat stopped");
  a_restart_rearm: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_RESTART
    && last && !cmd_wr |=> q.st == wrc_pkg::ST_ARMED && q.rd == '0)
    else $error("restart did not re-arm");
  a_fifo_refill: assert property (fifo_rd && q.fill == wrc_pkg::F_REFILL + wrc_pkg::F_ONE
    |=> q.irqs[wrc_pkg::I_REFILL]) else $error("refill request missing");
  a_multi_next: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_MULTI
    && last && !cmd_wr |=> q.st == wrc_pkg::ST_ARMED && q.rd == q.segb)
    else $error("segment advance wrong");
  a_gate_pause: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_GATE
    && !gate_ok |=> !dac_valid && $stable(q.rd)) else $error("gate ignored");
  a_under_flag: assert property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_FIFO
    && q.fill == '0 |=> q.irqs[wrc_pkg::I_UNDER] [*2]) else $error("underrun not sticky");
  a_fill_clear: assert property (reg_wr && reg_addr == wrc_pkg::A_MADDR
    |=> q.fill == '0) else $error("pointer load kept fill");
  a_hub_nojump: assert property (cmd_wr && reg_wdata[wrc_pkg::K_JUMP] && hub_synced
    && !q.jpend |=> !q.jpend) else $error("jump taken while synced");

  // Cover points of the main replay scenarios.
  c_single_run: cover property (q.st == wrc_pkg::ST_RUN && mode == wrc_pkg::M_SINGLE && last);
  c_fifo_under: cover property (ev[wrc_pkg::I_UNDER]);
  c_seq_jump:   cover property (q.jpend ##[1:40] !q.jpend && mode == wrc_pkg::M_SEQ);
  c_multi_wrap: cover property (mode == wrc_pkg::M_MULTI && last && nb > {1'b0, q.mend});

endmodule // wrc_top

// ### wrc_trig.sv
`timescale 1ns/100ps
// =====================================================================
// Pin synchronisers and external trigger qualification.
module wrc_trig (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Comparator, second input and gate pins.
  input  wire logic       cmp_hi_pin,
  input  wire logic       cmp_lo_pin,
  input  wire logic       trig2_pin,
  input  wire logic       gate_pin,
  // Condition selects.
  input  wire logic [1:0] t1_mode,
  input  wire logic [1:0] t2_mode,
  // Qualified results.
  output logic            t1_hit,
  output logic            t2_hit,
  output logic            gate_lvl
);

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] f;
    logic [3:0] fp;
    logic       arm;
    logic       hyst;
  } wrc_trig_st_t;

  wrc_trig_st_t q;
  wrc_trig_st_t d;
  logic hi, lo, hip, lop, rise;

  assign hi   = q.f[0];
  assign lo   = q.f[1];
  assign hip  = q.fp[0];
  assign lop  = q.fp[1];
  assign rise = hi & ~hip;

  // A level change is taken once the second and third stage agree.
  always_comb begin
    d      = q;
    d.s1   = {gate_pin, trig2_pin, cmp_lo_pin, cmp_hi_pin};
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.f    = (q.f & (q.s2 ^ q.s3)) | (q.s3 & ~(q.s2 ^ q.s3));
    d.fp   = q.f;
    d.arm  = ~lo ? 1'b1 : (rise ? 1'b0 : q.arm);
    d.hyst = hi ? 1'b1 : (~lo ? 1'b0 : q.hyst);
  end

  // Input one: two comparators give edge, window, hysteresis, re-arm.
  always_comb begin
    case (t1_mode)
      2'h0:    t1_hit = rise;
      2'h1:    t1_hit = (lo & ~hi) & ~(lop & ~hip);
      2'h2:    t1_hit = ~lo & lop & q.hyst;
      2'h3:    t1_hit = rise & q.arm;
      default: t1_hit = 1'b0;
    endcase
  end

  // Input two: one logic-level pin, edge or level only.
  always_comb begin
    case (t2_mode)
      2'h0:    t2_hit = q.f[2] & ~q.fp[2];
      2'h1:    t2_hit = ~q.f[2] & q.fp[2];
      2'h2:    t2_hit = q.f[2];
      2'h3:    t2_hit = ~q.f[2];
      default: t2_hit = 1'b0;
    endcase
  end

  assign gate_lvl = q.f[3];

  // State register.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // wrc_trig
